//--- zero_delay_output_sync.sv
// Distribution output synchronizer with active-reference edge detection.
//
// Functional notes
// - Source 01 selects active-reference synchronization.
// - Bit 4 set with bit 5 clear (source 01) disables the direct path.
// - Detector watches the currently active reference.
// - Primary sync is OR of four sources.
// - Armed detector output high stalls unmasked dividers.
// - First reference rising edge releases the dividers.
// - One-shot sync; rearm needs new primary edge.
// - Release is reclocked into the divider clock.
// - Reclocking adds four or five clock periods.
// - Then one divider output period follows.
// - Set mask bit exempts a channel.
// - Masked channels keep running during stall.
// - Source 00 syncs on primary falling edge.
// - Software sync bit one-to-zero is the event.
// - Source 10 syncs on feedback rollover edge.
`timescale 1ns/10ps
module zero_delay_output_sync (
  // Clock, reset and clock enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [zero_delay_sync_pkg::ADDR_W-1:0] paddr,
  input wire logic [zero_delay_sync_pkg::DATA_W-1:0] pwdata,
  output logic [zero_delay_sync_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sync sources, references and feedback.
  input wire logic auto_sync,
  input wire logic pin_sync,
  input wire logic eeprom_sync,
  input wire logic [zero_delay_sync_pkg::N_REF-1:0] ref_in,
  input wire logic [zero_delay_sync_pkg::REF_SEL_W-1:0] active_ref_sel,
  input wire logic fb_rollover,
  // Distribution.
  output logic [zero_delay_sync_pkg::N_CHAN-1:0] chan_out,
  output logic sync_pulse,
  output logic dist_stall
);

  localparam int NS = zero_delay_sync_pkg::N_SYNC_IN;
  localparam int NE = zero_delay_sync_pkg::N_EXT_SYNC;
  localparam int NR = zero_delay_sync_pkg::N_REF;
  localparam int RS = zero_delay_sync_pkg::RELEASE_STAGES;

  logic [NS-1:0] in_s1_r;
  logic [NS-1:0] in_s2_r;
  logic prim_prev_r;
  logic ref_prev_r;
  logic fb_prev_r;
  logic primary;
  logic prim_rise;
  logic prim_fall;
  logic ref_sel;
  logic ref_edge;
  logic fb_edge;
  logic [1:0] src;
  logic [zero_delay_sync_pkg::N_CHAN-1:0] mask;
  zero_delay_sync_pkg::det_state_type state_r;
  zero_delay_sync_pkg::det_state_type state_nxt;
  logic [RS-1:0] rel_r;
  logic [RS-1:0] rel_nxt;
  logic [zero_delay_sync_pkg::CTRL_W-1:0] ctrl_r;
  logic [zero_delay_sync_pkg::CTRL_W-1:0] ctrl_nxt;
  logic sw_sync_r;
  logic sw_sync_nxt;
  logic [15:0] div_r;
  logic [15:0] div_nxt;
  logic [31:0] prdata_nxt;
  logic pready_nxt;
  logic pslverr_nxt;
  logic setup;
  logic access;
  logic [13:0] idx;
  logic aligned;
  logic [31:0] status;

  // Pins and the references cross two flip-flops before use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1_r <= '0;
      in_s2_r <= '0;
    end else if (ce) begin
      in_s1_r <= {fb_rollover, ref_in, eeprom_sync, pin_sync, auto_sync};
      in_s2_r <= in_s1_r;
    end
  end

  assign src = ctrl_r[zero_delay_sync_pkg::SRC_LSB +: zero_delay_sync_pkg::SRC_W];
  assign mask = ctrl_r[zero_delay_sync_pkg::MASK_LSB +: zero_delay_sync_pkg::N_CHAN];
  // Any one of the four sources drives the primary sync signal.
  assign primary = sw_sync_r | (|in_s2_r[NE-1:0]);
  assign prim_rise = primary & ~prim_prev_r;
  // A set-then-clear of the software bit ends up as a falling edge here.
  assign prim_fall = ~primary & prim_prev_r;
  // The selected reference follows the active reference automatically.
  assign ref_sel = in_s2_r[NE + 32'(active_ref_sel)];
  assign ref_edge = ref_sel & ~ref_prev_r;
  assign fb_edge = in_s2_r[NE + NR] & ~fb_prev_r;

  // Edge detector.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      zero_delay_sync_pkg::DET_IDLE: begin
        // Only a new primary rising edge arms again.
        if (prim_rise) begin
          if (src == zero_delay_sync_pkg::SRC_REF || src == zero_delay_sync_pkg::SRC_FB) begin
            state_nxt = zero_delay_sync_pkg::DET_ARMED;
          end else begin
            state_nxt = zero_delay_sync_pkg::DET_DIRECT;
          end
        end
      end
      zero_delay_sync_pkg::DET_ARMED: begin
        if (src == zero_delay_sync_pkg::SRC_REF) begin
          if (ref_edge) begin
            state_nxt = zero_delay_sync_pkg::DET_IDLE;
          end
        end else if (src == zero_delay_sync_pkg::SRC_FB) begin
          if (fb_edge) begin
            state_nxt = zero_delay_sync_pkg::DET_IDLE;
          end
        end else begin
          state_nxt = zero_delay_sync_pkg::DET_IDLE;
        end
      end
      zero_delay_sync_pkg::DET_DIRECT: begin
        // The reference path disables the direct path.
        if (prim_fall || src == zero_delay_sync_pkg::SRC_REF) begin
          state_nxt = zero_delay_sync_pkg::DET_IDLE;
        end
      end
      default: begin
        state_nxt = zero_delay_sync_pkg::DET_IDLE;
      end
    endcase
    // The release is reclocked before it reaches the dividers.
    rel_nxt = {rel_r[RS-2:0], sync_pulse};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= zero_delay_sync_pkg::DET_IDLE;
      sync_pulse <= 1'b0;
      rel_r <= '0;
      dist_stall <= 1'b0;
      prim_prev_r <= 1'b0;
      ref_prev_r <= 1'b0;
      fb_prev_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      // Output goes high as soon as the detector is armed.
      sync_pulse <= (state_nxt != zero_delay_sync_pkg::DET_IDLE);
      rel_r <= rel_nxt;
      dist_stall <= rel_nxt[RS-1];
      prim_prev_r <= primary;
      ref_prev_r <= ref_sel;
      fb_prev_r <= in_s2_r[NE + NR];
    end
  end

  // Channel dividers; a masked channel never sees the stall.
  for (genvar i = 0; i < zero_delay_sync_pkg::N_CHAN; i++) begin : g_chan
    chan_divider u_div (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .stall(dist_stall & ~mask[i]),
      .divide_factor(div_r[i*zero_delay_sync_pkg::DIV_W +: zero_delay_sync_pkg::DIV_W]),
      .clk_out(chan_out[i])
    );
  end

  // APB slave, answering in the first access cycle.
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign idx = paddr[15:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign status = {27'h0000000, (state_r == zero_delay_sync_pkg::DET_ARMED), chan_out,
                   dist_stall, sync_pulse};

  always_comb begin
    ctrl_nxt = ctrl_r;
    sw_sync_nxt = sw_sync_r;
    div_nxt = div_r;
    prdata_nxt = prdata;
    pready_nxt = setup;
    pslverr_nxt = 1'b0;
    if (setup) begin
      prdata_nxt = '0;
      if (aligned && idx == zero_delay_sync_pkg::IDX_SYNC_CTRL) begin
        prdata_nxt = {24'h000000, ctrl_r};
      end else if (aligned && idx == zero_delay_sync_pkg::IDX_SW_SYNC) begin
        prdata_nxt[zero_delay_sync_pkg::SW_SYNC_BIT] = sw_sync_r;
      end else if (aligned && idx == zero_delay_sync_pkg::IDX_DIV) begin
        prdata_nxt = {16'h0000, div_r};
      end else if (aligned && idx == zero_delay_sync_pkg::IDX_STATUS) begin
        prdata_nxt = status;
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
    if (access && pwrite && aligned) begin
      if (idx == zero_delay_sync_pkg::IDX_SYNC_CTRL) begin
        ctrl_nxt = pwdata[zero_delay_sync_pkg::CTRL_W-1:0];
      end else if (idx == zero_delay_sync_pkg::IDX_SW_SYNC) begin
        sw_sync_nxt = pwdata[zero_delay_sync_pkg::SW_SYNC_BIT];
      end else if (idx == zero_delay_sync_pkg::IDX_DIV) begin
        div_nxt = pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= zero_delay_sync_pkg::SYNC_CTRL_RESET;
      sw_sync_r <= 1'b0;
      div_r <= zero_delay_sync_pkg::DIV_RESET;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      ctrl_r <= ctrl_nxt;
      sw_sync_r <= sw_sync_nxt;
      div_r <= div_nxt;
      prdata <= prdata_nxt;
      pready <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // Helper that measures release-to-first-edge latency of channel 0.
  logic stall_prev_r;
  logic lat_on_r;
  logic [8:0] lat_r;
  logic [8:0] q0;
  assign q0 = (div_r[7:0] == 8'h00) ? 9'h001 : {1'b0, div_r[7:0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_prev_r <= 1'b0;
      lat_on_r <= 1'b0;
      lat_r <= '0;
    end else if (ce) begin
      stall_prev_r <= dist_stall;
      if (stall_prev_r && !dist_stall && !mask[0]) begin
        lat_on_r <= 1'b1;
        lat_r <= 9'h001;
      end else if (chan_out[0]) begin
        lat_on_r <= 1'b0;
      end else if (lat_on_r) begin
        lat_r <= lat_r + 9'h001;
      end
    end
  end

  AST_REF_ARMS: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_r == zero_delay_sync_pkg::DET_IDLE && prim_rise &&
     src == zero_delay_sync_pkg::SRC_REF) |=> (state_r == zero_delay_sync_pkg::DET_ARMED))
    else $error("reference mode did not arm");

  AST_NO_DIRECT_IN_REF: assert property (@(posedge pclk) disable iff (!presetn)
    (src == zero_delay_sync_pkg::SRC_REF && $past(src) == zero_delay_sync_pkg::SRC_REF &&
     $past(ce)) |-> (state_r != zero_delay_sync_pkg::DET_DIRECT))
    else $error("direct path active in reference mode");

  AST_REF_EDGE_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_r == zero_delay_sync_pkg::DET_ARMED && src == zero_delay_sync_pkg::SRC_REF
     && ref_edge) ##1 ce [*3] |-> !sync_pulse ##2 !dist_stall)
    else $error("reference edge did not release");

  AST_ARM_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_r == zero_delay_sync_pkg::DET_IDLE && prim_rise) |=> sync_pulse)
    else $error("detector output not high when armed");

  AST_RECLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && $past(ce) && $past(ce, 2)) |-> (dist_stall == $past(sync_pulse, 2)))
    else $error("release not delayed by two cycles");

  AST_ONE_SHOT: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_r == zero_delay_sync_pkg::DET_IDLE && !prim_rise) |=>
     (state_r == zero_delay_sync_pkg::DET_IDLE))
    else $error("detector rearmed without primary edge");

  AST_DIRECT_FALL: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_r == zero_delay_sync_pkg::DET_DIRECT && prim_fall) |=> !sync_pulse)
    else $error("direct falling edge did not release");

  AST_FB_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && state_r == zero_delay_sync_pkg::DET_ARMED && src == zero_delay_sync_pkg::SRC_FB
     && !fb_edge) |=> (state_r == zero_delay_sync_pkg::DET_ARMED))
    else $error("feedback mode released without rollover");

  AST_STALL_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    (dist_stall && !mask[0]) ##1 (dist_stall && !mask[0]) |-> !chan_out[0])
    else $error("stalled channel output not low");

  AST_LATENCY: assert property (@(posedge pclk) disable iff (!presetn)
    (lat_on_r && $rose(chan_out[0])) |-> (lat_r == q0))
    else $error("restart latency wrong");

  AST_APB_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && psel && !penable) |=> pready)
    else $error("apb access not answered in one cycle");

  COV_REF_SYNC: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == zero_delay_sync_pkg::DET_ARMED && src == zero_delay_sync_pkg::SRC_REF
    && ref_edge);
  COV_DIRECT_SYNC: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == zero_delay_sync_pkg::DET_DIRECT && prim_fall);
  COV_FB_SYNC: cover property (@(posedge pclk) disable iff (!presetn)
    state_r == zero_delay_sync_pkg::DET_ARMED && src == zero_delay_sync_pkg::SRC_FB && fb_edge);
  COV_MASKED_RUN: cover property (@(posedge pclk) disable iff (!presetn)
    dist_stall && mask[1] && $rose(chan_out[1]));

endmodule

//--- zero_delay_sync_pkg.sv
// Shared constants and types for the zero-delay output synchronizer.
package zero_delay_sync_pkg;

  // Sizes.
  localparam int N_CHAN = 2;
  localparam int N_REF = 4;
  localparam int N_EXT_SYNC = 3;
  localparam int N_SYNC_IN = N_EXT_SYNC + N_REF + 1;
  localparam int DIV_W = 8;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int REF_SEL_W = 2;

  // Register indices; the byte address is four times the index.
  localparam logic [13:0] IDX_SYNC_CTRL = 14'h0402;
  localparam logic [13:0] IDX_SW_SYNC = 14'h0a02;
  localparam logic [13:0] IDX_DIV = 14'h0410;
  localparam logic [13:0] IDX_STATUS = 14'h0411;

  // Field positions.
  localparam int MASK_LSB = 0;
  localparam int SRC_LSB = 4;
  localparam int SRC_W = 2;
  localparam int CTRL_W = 8;
  localparam int SW_SYNC_BIT = 1;
  localparam int ST_DET = 0;
  localparam int ST_STALL = 1;
  localparam int ST_OUT_LSB = 2;
  localparam int ST_ARMED = 4;

  // Sync source encodings.
  localparam logic [1:0] SRC_DIRECT = 2'h0;
  localparam logic [1:0] SRC_REF = 2'h1;
  localparam logic [1:0] SRC_FB = 2'h2;

  // Reset values.
  localparam logic [7:0] SYNC_CTRL_RESET = 8'h00;
  localparam logic [15:0] DIV_RESET = 16'h0404;

  // Release reclocking depth after the detector output.
  localparam int RELEASE_STAGES = 2;

  typedef enum logic [1:0] {DET_IDLE, DET_ARMED, DET_DIRECT} det_state_type;

endpackage

//--- chan_divider.sv
// Output channel divider that can be stalled and restarted.
`timescale 1ns/10ps
module chan_divider (
  // Clock, reset and clock enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Control.
  input wire logic stall,
  input wire logic [zero_delay_sync_pkg::DIV_W-1:0] divide_factor,
  // Divided output.
  output logic clk_out
);

  logic [zero_delay_sync_pkg::DIV_W-1:0] cnt_r;
  logic [zero_delay_sync_pkg::DIV_W-1:0] cnt_nxt;
  logic started_r;
  logic started_nxt;
  logic out_nxt;
  logic [zero_delay_sync_pkg::DIV_W-1:0] q;
  logic [zero_delay_sync_pkg::DIV_W-1:0] hi;

  // A divide factor of zero behaves as one.
  assign q = (divide_factor == '0) ? 8'h01 : divide_factor;
  assign hi = {1'b0, q[7:1]} + {7'h00, q[0]};

  // First rising output edge comes one full output period after release.
  always_comb begin
    cnt_nxt = cnt_r;
    started_nxt = started_r;
    if (stall) begin
      cnt_nxt = '0;
      started_nxt = 1'b0;
    end else if (cnt_r == q - 8'h01) begin
      cnt_nxt = '0;
      started_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 8'h01;
    end
    out_nxt = started_nxt && (cnt_nxt < hi);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      started_r <= 1'b0;
      clk_out <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      started_r <= started_nxt;
      clk_out <= out_nxt;
    end
  end

endmodule

//--- zds_ref_model.sv
// Model of the reference clocks and primary sync sources around the synchronizer.
`timescale 1ns/10ps
module zds_ref_model (
  // Controls from the bench.
  input wire logic [3:0] ref_en,
  input wire logic [2:0] src_lvl,
  input wire logic fb_lvl,
  // Reference clocks, sync sources and feedback.
  output logic [3:0] ref_in,
  output logic auto_sync,
  output logic pin_sync,
  output logic eeprom_sync,
  output logic fb_rollover
);
  // Sync sources follow the bench; the device ORs them with its own bit.
  assign auto_sync = src_lvl[0];
  assign pin_sync = src_lvl[1];
  assign eeprom_sync = src_lvl[2];
  assign fb_rollover = fb_lvl;

  // Each reference is a free clock of its own rate; a disabled one rests low.
  for (genvar g = 0; g < 4; g++) begin : g_ref
    initial begin
      ref_in[g] = 1'b0;
      #3;
      forever begin
        #(37.5 + 25.0 * g);
        ref_in[g] = ref_en[g] & ~ref_in[g];
      end
    end
  end
endmodule

//--- tb_zero_delay_output_sync.sv
// Self-checking bench for the zero-delay output synchronizer.
`timescale 1ns/10ps
module tb_zero_delay_output_sync;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, fb_lvl;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic auto_sync, pin_sync, eeprom_sync, fb_rollover, sync_pulse, dist_stall, er, hi;
  logic [3:0] ref_in, ref_en;
  logic [2:0] src_lvl;
  logic [1:0] active_ref_sel, chan_out;
  int error_cnt, n_compared, n;

  zero_delay_output_sync uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .auto_sync(auto_sync), .pin_sync(pin_sync),
    .eeprom_sync(eeprom_sync), .ref_in(ref_in), .active_ref_sel(active_ref_sel),
    .fb_rollover(fb_rollover), .chan_out(chan_out), .sync_pulse(sync_pulse),
    .dist_stall(dist_stall));

  zds_ref_model partner (.ref_en(ref_en), .src_lvl(src_lvl), .fb_lvl(fb_lvl),
    .ref_in(ref_in), .auto_sync(auto_sync), .pin_sync(pin_sync),
    .eeprom_sync(eeprom_sync), .fb_rollover(fb_rollover));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic end_of_test();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic primary(input int s, input logic v);
    if (s == 3) begin
      apb(1'b1, zero_delay_sync_pkg::IDX_SW_SYNC, {30'h0, v, 1'b0});
    end else begin
      @(posedge pclk);
      src_lvl[s] <= v;
    end
  endtask

  task automatic wait_sp(input logic v);
    int k;
    k = 0;
    while (sync_pulse !== v && k < 200) begin
      @(posedge pclk);
      k++;
    end
  endtask

  task automatic arm_sw();
    primary(3, 1'b1);
    primary(3, 1'b0);
    wait_sp(1'b1);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    end_of_test();
  end

  initial begin
    error_cnt = 0;
    n_compared = 0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    ref_en = 4'h0;
    src_lvl = 3'h0;
    fb_lvl = 1'b0;
    active_ref_sel = 2'h2;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, zero_delay_sync_pkg::IDX_SYNC_CTRL, 32'h0);
    chk("ctrl_reset", {24'h0, zero_delay_sync_pkg::SYNC_CTRL_RESET}, rd);
    apb(1'b0, zero_delay_sync_pkg::IDX_DIV, 32'h0);
    chk("div_reset", {16'h0, zero_delay_sync_pkg::DIV_RESET}, rd);
    apb(1'b1, 14'h0123, 32'hff);
    chk("unmapped_err", 32'h1, {31'h0, er});
    // Direct modes, each primary source in turn.
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 4; s++) begin
        apb(1'b1, zero_delay_sync_pkg::IDX_SYNC_CTRL, (m == 1) ? 32'h30 : 32'h00);
        primary(s, 1'b1);
        wait_sp(1'b1);
        chk("direct_armed", 32'h1, {31'h0, sync_pulse});
        primary(s, 1'b0);
        wait_sp(1'b0);
        chk("direct_release", 32'h0, {31'h0, sync_pulse});
      end
    end
    // Active reference mode, two divide factors.
    for (int q = 4; q < 8; q += 3) begin
      apb(1'b1, zero_delay_sync_pkg::IDX_DIV, {24'h000004, q[7:0]});
      apb(1'b1, zero_delay_sync_pkg::IDX_SYNC_CTRL, 32'h10);
      @(posedge pclk);
      ref_en <= 4'b0010;
      arm_sw();
      repeat (40) @(posedge pclk);
      chk("other_ref_ignored", 32'h1, {31'h0, sync_pulse});
      chk("stalled_out", 32'h0, {30'h0, chan_out});
      chk("stall", 32'h1, {31'h0, dist_stall});
      ref_en <= 4'b0110;
      @(posedge ref_in[2]);
      n = 0;
      while (chan_out[0] !== 1'b1 && n < 60) begin
        @(posedge pclk);
        #1;
        n++;
      end
      chk("latency_in_range", 32'h1, {31'h0, (n >= q + 4 && n <= q + 5)});
      hi = 1'b0;
      repeat (60) begin
        @(posedge pclk);
        hi = hi | sync_pulse;
      end
      chk("one_shot", 32'h0, {31'h0, hi});
    end
    // Channel 0 masked: it runs on while channel 1 stalls.
    @(posedge pclk);
    ref_en <= 4'h0;
    apb(1'b1, zero_delay_sync_pkg::IDX_SYNC_CTRL, 32'h11);
    arm_sw();
    repeat (8) @(posedge pclk);
    // Clock enable low freezes the running channel as well.
    ce <= 1'b0;
    @(posedge pclk);
    rd = {30'h0, chan_out};
    repeat (10) begin
      @(posedge pclk);
      chk("ce_frozen", rd, {30'h0, chan_out});
    end
    ce <= 1'b1;
    hi = 1'b0;
    repeat (20) begin
      @(posedge pclk);
      hi = hi | chan_out[0];
      chk("unmasked_held", 32'h0, {31'h0, chan_out[1]});
    end
    chk("masked_runs", 32'h1, {31'h0, hi});
    // Feedback rollover mode ignores the reference.
    apb(1'b1, zero_delay_sync_pkg::IDX_SYNC_CTRL, 32'h00);
    apb(1'b1, zero_delay_sync_pkg::IDX_SYNC_CTRL, 32'h20);
    chk("arm_abandoned", 32'h0, {31'h0, sync_pulse});
    arm_sw();
    @(posedge pclk);
    ref_en <= 4'hf;
    repeat (30) @(posedge pclk);
    chk("fb_armed", 32'h1, {31'h0, sync_pulse});
    fb_lvl <= 1'b1;
    wait_sp(1'b0);
    chk("fb_release", 32'h0, {31'h0, sync_pulse});
    @(posedge pclk);
    fb_lvl <= 1'b0;
    repeat (10) @(posedge pclk);
    end_of_test();
  end
endmodule
